// File: core/port_status.sv
`timescale 1ns/1ps

// How it works
// (RL1) over-current bit follows the condition, read-only
// (RL2) enable change set only on EOF2 error disable
// (RL3) writing one clears enable change flag
// (RL4) writes of one to enabled are ignored
// (RL5) enabled set only after high-speed reset end
// (RL6) disconnect, fault or zero write disables port
// (RL7) enabled follows actual port state change
// (RL8) disabled port blocks downstream data except reset
// (RL9) every connect change sets connect change flag
// (RL10) writing one clears connect change flag
// (RL11) connect status shows present device now
// (RL12) port bits other than the over-current ones read zero without port power
// (RL13) all status bits reset to zero
// (RL14) over-current change set on active bit change
// (RL15) zero writes leave change flags untouched
module port_status
  import port_status_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire port_events_s  port_in,
  input  wire logic          down_data_valid,
  input  wire logic          down_reset_signal,
  output logic               down_data_pass,
  output logic               down_reset_pass,
  output logic               port_power,
  output logic               irq
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  bus_phase_e  phase;
  bus_phase_e  next_phase;
  logic [7:0]  addr_q;
  logic [7:0]  next_addr_q;
  logic        addr_phase;

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_comb
  begin
    next_phase  = BUS_IDLE;
    next_addr_q = addr_q;
    if (addr_phase)
    begin
      next_phase  = hwrite ? BUS_WRITE : BUS_READ;
      next_addr_q = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase  <= BUS_IDLE;
      addr_q <= 8'h00;
    end
    else
    begin
      phase  <= next_phase;
      addr_q <= next_addr_q;
    end
  end

  // hsize is accepted as word only; narrower writes act on the whole word
  function automatic logic wr_hit(input bus_phase_e ph, input logic [7:0] a, input logic [7:0] target);
    wr_hit = (ph == BUS_WRITE) && (a == target);
  endfunction

  logic wr_status;
  logic wr_ctrl;
  logic wr_iclr;
  logic wr_ien;

  assign wr_status = wr_hit(phase, addr_q, PORT_STATUS_ADDR);
  assign wr_ctrl   = wr_hit(phase, addr_q, PORT_CTRL_ADDR);
  assign wr_iclr   = wr_hit(phase, addr_q, IRQ_CLEAR_ADDR);
  assign wr_ien    = wr_hit(phase, addr_q, IRQ_ENABLE_ADDR);

  // ----------------------------------------------------------------
  // port state
  // ----------------------------------------------------------------
  logic no_power;
  logic connect_status;
  logic next_connect_status;
  logic oc_active;
  logic next_oc_active;
  logic enabled;
  logic next_enabled;
  logic connect_change_flag;
  logic enable_change_flag;
  logic oc_change_flag;
  logic error_disable;

  assign no_power      = !port_power;
  assign error_disable = enabled && port_in.port_error_eof2;

  always_comb
  begin
    next_oc_active      = port_in.overcurrent;                          // RL1
    next_connect_status = port_power && port_in.connected;              // RL11 RL12
    next_enabled        = enabled;
    if (port_in.reset_done_hs && port_in.connected)
    begin
      next_enabled = 1'b1;                                              // RL5
    end
    // a software one never enables; only a zero disables
    if (wr_status && !hwdata[PORT_ENABLED_BIT])
    begin
      next_enabled = 1'b0;                                              // RL4 RL6
    end
    // disable wins over enable; port state itself drives the bit
    if (port_in.fault || error_disable || !port_in.connected)
    begin
      next_enabled = 1'b0;                                              // RL6 RL7
    end
    if (no_power)
    begin
      next_enabled = 1'b0;                                              // RL12
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oc_active      <= 1'b0;                                           // RL13
      connect_status <= 1'b0;
      enabled        <= 1'b0;
    end
    else
    begin
      oc_active      <= next_oc_active;
      connect_status <= next_connect_status;
      enabled        <= next_enabled;
    end
  end

  change_flag u_connect_change
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .set        (next_connect_status != connect_status),               // RL9
    .clear      (wr_status && hwdata[CONNECT_CHANGE_BIT]),             // RL10 RL15
    .force_zero (no_power),                                            // RL12
    .flag       (connect_change_flag)
  );

  change_flag u_enable_change
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .set        (error_disable),                                        // RL2
    .clear      (wr_status && hwdata[ENABLE_CHANGE_BIT]),              // RL3 RL15
    .force_zero (no_power),                                            // RL12
    .flag       (enable_change_flag)
  );

  change_flag u_oc_change
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .set        (next_oc_active != oc_active),                          // RL14
    .clear      (wr_status && hwdata[OC_CHANGE_BIT]),                  // RL14
    .force_zero (1'b0),
    .flag       (oc_change_flag)
  );

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [NUM_EVENTS-1:0] irq_status;
  logic [NUM_EVENTS-1:0] next_irq_status;
  logic [NUM_EVENTS-1:0] irq_enable;
  logic [NUM_EVENTS-1:0] next_irq_enable;
  logic [NUM_EVENTS-1:0] irq_events;

  assign irq_events[EVT_CONNECT]     = next_connect_status != connect_status;
  assign irq_events[EVT_ENABLE]      = error_disable;
  assign irq_events[EVT_OVERCURRENT] = next_oc_active != oc_active;

  // set wins over a clear in the same cycle
  always_comb
  begin
    next_irq_status = irq_status;
    next_irq_enable = irq_enable;
    if (wr_iclr)
    begin
      next_irq_status = irq_status & ~hwdata[NUM_EVENTS-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
    if (wr_ien)
    begin
      next_irq_enable = hwdata[NUM_EVENTS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status <= IRQ_RESET;
      irq_enable <= IRQ_RESET;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [31:0] next_hrdata;
  logic [5:0]  status_word;
  logic        next_port_power;

  always_comb
  begin
    status_word                     = PORT_STATUS_RESET;
    status_word[CONNECT_STATUS_BIT] = connect_status;                  // RL11
    status_word[CONNECT_CHANGE_BIT] = connect_change_flag;
    status_word[PORT_ENABLED_BIT]   = enabled;
    status_word[ENABLE_CHANGE_BIT]  = enable_change_flag;
    status_word[OC_ACTIVE_BIT]      = oc_active;                       // RL1
    status_word[OC_CHANGE_BIT]      = oc_change_flag;
    next_hrdata = 32'h0000_0000;
    if (next_phase == BUS_READ)
    begin
      case (next_addr_q)
        PORT_STATUS_ADDR: next_hrdata = {26'h0, status_word};
        PORT_CTRL_ADDR:   next_hrdata = {31'h0, port_power};
        IRQ_STATUS_ADDR:  next_hrdata = {29'h0, irq_status};
        IRQ_ENABLE_ADDR:  next_hrdata = {29'h0, irq_enable};
        default:          next_hrdata = 32'h0000_0000;
      endcase
    end
    next_port_power = wr_ctrl ? hwdata[PORT_POWER_BIT] : port_power;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata          <= 32'h0000_0000;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      port_power      <= PORT_POWER_RESET;
      irq             <= 1'b0;
      down_data_pass  <= 1'b0;
      down_reset_pass <= 1'b0;
    end
    else
    begin
      hrdata          <= next_hrdata;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      port_power      <= next_port_power;
      irq             <= |(next_irq_status & next_irq_enable);
      down_data_pass  <= down_data_valid && next_enabled;              // RL8
      down_reset_pass <= down_reset_signal && next_port_power;         // RL8
    end
  end

endmodule

// File: core/port_status_pkg.sv
package port_status_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_STATUS_ADDR = 8'h00;
  localparam logic [7:0] PORT_CTRL_ADDR   = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_ADDR   = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h10;

  // ----------------------------------------------------------------
  // port status and port control field positions
  // ----------------------------------------------------------------
  localparam int CONNECT_STATUS_BIT = 0;
  localparam int CONNECT_CHANGE_BIT = 1;
  localparam int PORT_ENABLED_BIT   = 2;
  localparam int ENABLE_CHANGE_BIT  = 3;
  localparam int OC_ACTIVE_BIT      = 4;
  localparam int OC_CHANGE_BIT      = 5;
  localparam int PORT_POWER_BIT     = 0;

  // ----------------------------------------------------------------
  // interrupt event positions
  // ----------------------------------------------------------------
  localparam int NUM_EVENTS       = 3;
  localparam int EVT_CONNECT      = 0;
  localparam int EVT_ENABLE       = 1;
  localparam int EVT_OVERCURRENT  = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] PORT_STATUS_RESET = 6'h00;
  localparam logic       PORT_POWER_RESET  = 1'b0;
  localparam logic [2:0] IRQ_RESET         = 3'h0;

  // ----------------------------------------------------------------
  // ahb encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0]
  {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b11
  } bus_phase_e;

  typedef struct packed
  {
    logic       overcurrent;
    logic       connected;
    logic       reset_done_hs;
    logic       port_error_eof2;
    logic       fault;
  } port_events_s;

endpackage

// File: core/change_flag.sv
`timescale 1ns/1ps

// sticky write-one-to-clear flag; a set in the clearing cycle wins
module change_flag
  import port_status_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set,
  input  wire logic clear,
  input  wire logic force_zero,
  output logic      flag
);

  logic next_flag;

  always_comb
  begin
    next_flag = flag;
    if (clear)
    begin
      next_flag = 1'b0;
    end
    if (set)
    begin
      next_flag = 1'b1;
    end
    if (force_zero)
    begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
    end
  end

endmodule

// File: bench/port_status_monitor.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// bus and port-side checks, ports of port_status only
// ------------------------------------------------------------
module port_status_monitor
  import port_status_pkg::*;
(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         hsel,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  input wire logic         hreadyout,
  input wire logic         hresp,
  input wire port_events_s port_in,
  input wire logic         down_data_valid,
  input wire logic         down_reset_signal,
  input wire logic         down_data_pass,
  input wire logic         down_reset_pass,
  input wire logic         port_power
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_no_read;
    !(hsel && hready && htrans[1] && !hwrite);
  endsequence

  sequence s_unpowered;
    !port_power ##1 !port_power;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  a_rdata_idle: assert property (s_no_read |=> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_pass_valid: assert property (down_data_pass |-> $past(down_data_valid))
    else $error("data passed without request");
  // the pass flop uses the power bit as it is being written, so pair the old request with the new power level
  a_reset_pass: assert property (down_reset_pass == ($past(down_reset_signal) && port_power))
    else $error("reset signalling not passed");
  a_power_blocks: assert property (s_unpowered |=> !down_data_pass)
    else $error("data passed without power");
  a_fault_blocks: assert property ($past(port_in.fault) |-> !down_data_pass)
    else $error("data passed after fault");
  a_unplug_blocks: assert property (!$past(port_in.connected) |-> !down_data_pass)
    else $error("data passed while disconnected");
  a_error_blocks: assert property ($past(port_in.port_error_eof2) |-> !down_data_pass)
    else $error("data passed after port error");
endmodule

bind port_status port_status_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .port_in(port_in), .down_data_valid(down_data_valid), .down_reset_signal(down_reset_signal),
  .down_data_pass(down_data_pass), .down_reset_pass(down_reset_pass), .port_power(port_power));

// File: bench/usb_device_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// attached device: plug, over-current and port events
// ------------------------------------------------------------
module usb_device_model
  import port_status_pkg::*;
(
  input  wire logic   hclk,
  output port_events_s port_in
);
  initial port_in = '0;

  // called right after a rising edge; levels hold until changed
  task automatic level(input int i, input logic v);
    port_in[i] <= v;
  endtask

  // one-cycle event, so a stuck event cannot hide a missed edge
  task automatic pulse(input int i);
    port_in[i] <= 1'b1;
    @(posedge hclk);
    port_in[i] <= 1'b0;
  endtask
endmodule

// File: bench/usb_host_port_status_low_bits_bench.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module usb_host_port_status_low_bits_bench;
  import port_status_pkg::*;
  logic         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, down_data_valid = 0, down_reset_signal = 0;
  logic [31:0]  haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]   htrans = 0;
  logic [2:0]   hsize = 0;
  logic         hreadyout, hresp, down_data_pass, down_reset_pass, port_power, irq;
  port_events_s port_in;
  int           failures = 0, samples_checked = 0;

  always #4 hclk = ~hclk;

  usb_device_model dev (.hclk(hclk), .port_in(port_in));
  port_status uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_in(port_in), .down_data_valid(down_data_valid),
    .down_reset_signal(down_reset_signal), .down_data_pass(down_data_pass),
    .down_reset_pass(down_reset_pass), .port_power(port_power), .irq(irq));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after an edge; waits on hready, no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic t_reset_values;
    rc("status", PORT_STATUS_ADDR, 32'h0);
    rc("control", PORT_CTRL_ADDR, 32'h0);
    rc("irq_status", IRQ_STATUS_ADDR, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
  endtask

  task automatic t_connect;
    wr(PORT_CTRL_ADDR, 32'h1);
    wr(IRQ_ENABLE_ADDR, 32'h7);
    dev.level(3, 1'b1);
    step(2);
    rc("status", PORT_STATUS_ADDR, 32'h3);
    check("irq", 32'h1, {31'h0, irq});
    dev.level(3, 1'b0);
    step(1);
    dev.level(3, 1'b1);
    step(2);
    rc("status", PORT_STATUS_ADDR, 32'h3);
    wr(PORT_STATUS_ADDR, 32'h0);
    rc("status", PORT_STATUS_ADDR, 32'h3);
    wr(PORT_STATUS_ADDR, 32'h2);
    rc("status", PORT_STATUS_ADDR, 32'h1);
    wr(IRQ_CLEAR_ADDR, 32'h1);
    step(2);
    check("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_enable;
    down_reset_signal <= 1'b1;
    down_data_valid <= 1'b1;
    step(2);
    check("reset_pass", 32'h1, {31'h0, down_reset_pass});
    check("data_pass", 32'h0, {31'h0, down_data_pass});
    wr(PORT_STATUS_ADDR, 32'h4);
    rc("status", PORT_STATUS_ADDR, 32'h1);
    dev.pulse(2);
    step(2);
    rc("status", PORT_STATUS_ADDR, 32'h5);
    check("data_pass", 32'h1, {31'h0, down_data_pass});
    down_data_valid <= 1'b0;
    step(2);
    check("data_pass", 32'h0, {31'h0, down_data_pass});
    down_data_valid <= 1'b1;
    step(2);
    check("data_pass", 32'h1, {31'h0, down_data_pass});
    dev.pulse(1);
    step(2);
    check("data_pass", 32'h0, {31'h0, down_data_pass});
    rc("status", PORT_STATUS_ADDR, 32'h9);
    rc("irq_status", IRQ_STATUS_ADDR, 32'h2);
    wr(PORT_STATUS_ADDR, 32'h8);
    rc("status", PORT_STATUS_ADDR, 32'h1);
    dev.pulse(2);
    step(2);
    wr(PORT_STATUS_ADDR, 32'h0);
    rc("status", PORT_STATUS_ADDR, 32'h1);
    dev.pulse(2);
    step(2);
    dev.pulse(0);
    step(2);
    rc("status", PORT_STATUS_ADDR, 32'h1);
    wr(IRQ_CLEAR_ADDR, 32'h7);
  endtask

  task automatic t_overcurrent;
    dev.level(4, 1'b1);
    step(2);
    rc("status", PORT_STATUS_ADDR, 32'h31);
    rc("irq_status", IRQ_STATUS_ADDR, 32'h4);
    dev.level(4, 1'b0);
    step(2);
    rc("status", PORT_STATUS_ADDR, 32'h21);
    wr(PORT_STATUS_ADDR, 32'h20);
    rc("status", PORT_STATUS_ADDR, 32'h1);
  endtask

  task automatic t_power_off;
    dev.pulse(2);
    step(2);
    wr(PORT_CTRL_ADDR, 32'h0);
    step(2);
    rc("status", PORT_STATUS_ADDR, 32'h0);
    check("reset_pass", 32'h0, {31'h0, down_reset_pass});
    check("data_pass", 32'h0, {31'h0, down_data_pass});
    down_reset_signal <= 1'b0;
    wr(PORT_CTRL_ADDR, 32'h1);
    step(2);
    check("reset_pass", 32'h0, {31'h0, down_reset_pass});
    down_reset_signal <= 1'b1;
    step(2);
    check("reset_pass", 32'h1, {31'h0, down_reset_pass});
    check("data_pass", 32'h0, {31'h0, down_data_pass});
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_connect();
    t_enable();
    t_overcurrent();
    t_power_off();
    final_report();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #(8 * 4000);
    failures++;
    final_report();
  end
endmodule
